// ---- verilog/emb_top.sv ----
`timescale 1ns/1ps
module emb_top #(
	parameter int          SB_CYC     = emb_pkg::SB_LONG_CYC,
	parameter logic [31:0] EMU_BASE   = 32'h0040_0000,
	parameter logic [31:0] EMU_SIZE   = 32'h0004_0000,
	parameter logic [15:0] BRK_OPCODE = 16'h0A5A
) (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        tb_valid,
	input  wire logic        tb_write,
	input  wire logic        tb_fetch,
	input  wire logic        tb_slot,
	input  wire logic [1:0]  tb_size,
	input  wire logic [31:0] tb_addr,
	input  wire logic [31:0] tb_data,
	input  wire logic        cpu_sleep,
	input  wire logic        hold_ack,
	output logic             hold_req,
	output logic             mem_req,
	output logic             mem_we,
	output logic      [31:0] mem_addr,
	output logic      [31:0] mem_wdata,
	input  wire logic        mem_ack,
	input  wire logic [31:0] mem_rdata,
	output logic             subst_en,
	output logic      [31:0] subst_addr,
	output logic      [15:0] subst_op,
	output logic             brk_req,
	output logic             trig_out,
	output logic             slot_illegal
);
	typedef struct packed {
		logic [31:0]              ctrl;
		logic                     rt_lost;
		logic                     acc_err;
		logic                     brk_seen;
		logic [31:0]              mon_fmt;
		logic [7:0][26:0]         mon_base;
		logic [7:0]               mon_en;
		logic [63:0][31:0]        mon_mem;
		logic [31:0]              acc_addr;
		logic [31:0]              acc_data;
		logic                     acc_wr;
		logic                     acc_sb;
		emb_pkg::emb_acc_t        acc;
		logic [31:0]              acc_tmr;
		logic [3:0]               mon_pause;
		logic [31:0]              sw_addr;
		logic [15:0]              sw_orig;
		logic                     sw_en;
		logic                     sw_act;
		logic [3:0][31:0]         ch_addr;
		logic [3:0][31:0]         ch_data;
		logic [3:0][31:0]         ch_cfg;
		logic [1:0]               seq;
		logic                     pready;
		logic                     pslverr;
		logic [31:0]              prdata;
		logic                     brk_req;
		logic                     trig_out;
		logic                     slot_illegal;
		logic                     hold_req;
		logic                     mem_req;
	} emb_top_st_t;

	emb_top_st_t st;
	emb_top_st_t next_st;
	logic [11:0] a;
	logic        map_ok;
	logic        apb_acc;
	logic        apb_wr;
	logic        sw_ok;
	logic        sw_hit;
	logic        go_cmd;
	logic        mon_cfg_wr;
	logic [3:0]  h;

	emb_chan_if ch_if[emb_pkg::BRK_CH] ();

	// register decode; upper address bits must be zero to be mapped
	assign a       = {paddr[11:2], 2'h0};
	assign map_ok  = (paddr[31:12] == 20'h00000) && (a < emb_pkg::OFF_MEMEND)
		&& !((a >= emb_pkg::OFF_CHEND) && (a < emb_pkg::OFF_MONMEM));
	assign apb_acc = psel & penable & ~st.pready;
	assign apb_wr  = psel & penable & pwrite & st.pready & ~st.pslverr;
	assign go_cmd  = apb_wr && (a == emb_pkg::OFF_ACCC) && pwdata[emb_pkg::CMD_GO];
	assign mon_cfg_wr = apb_wr && ((a == emb_pkg::OFF_MONFMT)
		|| ((a >= emb_pkg::OFF_MONW) && (a < emb_pkg::OFF_CHAN)));

	// a software breakpoint may only sit in emulation RAM over a nonzero halfword
	assign sw_ok  = (st.sw_addr >= EMU_BASE) && (st.sw_addr < EMU_BASE + EMU_SIZE)
		&& (st.sw_orig != 16'h0000);
	assign sw_hit = st.sw_act & tb_valid & tb_fetch & (tb_addr[31:1] == st.sw_addr[31:1]);

	// break channels; only the last one counts satisfactions
	for (genvar i = 0; i < emb_pkg::BRK_CH; i++) begin : g_ch
		assign ch_if[i].en     = st.ch_cfg[i][emb_pkg::CFG_EN];
		assign ch_if[i].aen    = st.ch_cfg[i][emb_pkg::CFG_AEN];
		assign ch_if[i].den    = st.ch_cfg[i][emb_pkg::CFG_DEN];
		assign ch_if[i].size   = st.ch_cfg[i][emb_pkg::CFG_SZ +: 2];
		assign ch_if[i].count  = st.ch_cfg[i][emb_pkg::CFG_CNT +: 16];
		assign ch_if[i].addr   = st.ch_addr[i];
		assign ch_if[i].data   = st.ch_data[i];
		assign ch_if[i].bvalid = tb_valid;
		assign ch_if[i].baddr  = tb_addr;
		assign ch_if[i].bdata  = tb_data;
		assign ch_if[i].bsize  = tb_size;
		assign h[i]            = ch_if[i].hit;
		emb_chan #(
			.HAS_COUNT (i == emb_pkg::BRK_CNT_IDX)
		) u_chan (
			.clk    (clk),
			.arst_n (arst_n),
			.cif    (ch_if[i])
		);
	end

	always_comb begin
		logic [31:0] rd;
		logic [5:0]  idx;
		logic [31:0] old;
		logic        fire;
		logic [4:0]  sh;
		rd   = 32'h0000_0000;
		idx  = 6'h00;
		old  = 32'h0000_0000;
		fire = 1'b0;
		sh   = 5'h00;
		next_st = st;
		next_st.pready       = 1'b0;
		next_st.pslverr      = 1'b0;
		next_st.brk_req      = 1'b0;
		next_st.trig_out     = 1'b0;
		next_st.slot_illegal = 1'b0;

		// read mux, answered one cycle into the access phase
		if (a == emb_pkg::OFF_CTRL) begin
			rd = st.ctrl;
		end else if (a == emb_pkg::OFF_STAT) begin
			rd = {25'h0, st.seq, st.sw_act, st.brk_seen, st.acc_err,
				(st.acc != emb_pkg::ACC_IDLE), st.rt_lost};
		end else if (a == emb_pkg::OFF_SWBP) begin
			rd = {st.sw_addr[31:1], st.sw_en};
		end else if (a == emb_pkg::OFF_SWORIG) begin
			rd = {16'h0000, st.sw_orig};
		end else if (a == emb_pkg::OFF_ACCA) begin
			rd = st.acc_addr;
		end else if (a == emb_pkg::OFF_ACCD) begin
			rd = st.acc_data;
		end else if (a == emb_pkg::OFF_ACCC) begin
			rd = {29'h0, st.acc_sb, st.acc_wr, 1'b0};
		end else if (a == emb_pkg::OFF_MONFMT) begin
			rd = st.mon_fmt;
		end else if (a < emb_pkg::OFF_CHAN) begin
			rd = {st.mon_base[a[4:2]], 4'h0, st.mon_en[a[4:2]]};
		end else if (a < emb_pkg::OFF_CHEND) begin
			rd = (a[3:2] == 2'h0) ? st.ch_addr[a[5:4]] :
				(a[3:2] == 2'h1) ? st.ch_data[a[5:4]] : st.ch_cfg[a[5:4]];
		end else begin
			rd = st.mon_mem[a[7:2]];
		end
		if (apb_acc) begin
			next_st.pready  = 1'b1;
			next_st.pslverr = ~map_ok;
			next_st.prdata  = map_ok ? rd : 32'h0000_0000;
		end

		// writes land at the edge that completes the access
		if (apb_wr) begin
			if (a == emb_pkg::OFF_CTRL) begin
				next_st.ctrl = pwdata;
			end else if (a == emb_pkg::OFF_STAT) begin
				next_st.rt_lost  = st.rt_lost & ~pwdata[emb_pkg::ST_RTLOST];
				next_st.acc_err  = st.acc_err & ~pwdata[emb_pkg::ST_ACCERR];
				next_st.brk_seen = st.brk_seen & ~pwdata[emb_pkg::ST_BRK];
			end else if (a == emb_pkg::OFF_SWBP) begin
				next_st.sw_addr = {pwdata[31:1], 1'b0};
				next_st.sw_en   = pwdata[0];
			end else if (a == emb_pkg::OFF_SWORIG) begin
				next_st.sw_orig = pwdata[15:0];
			end else if (a == emb_pkg::OFF_ACCA) begin
				next_st.acc_addr = (st.acc == emb_pkg::ACC_IDLE) ? pwdata : st.acc_addr;
			end else if (a == emb_pkg::OFF_ACCD) begin
				next_st.acc_data = (st.acc == emb_pkg::ACC_IDLE) ? pwdata : st.acc_data;
			end else if (a == emb_pkg::OFF_MONFMT) begin
				next_st.mon_fmt = pwdata;
			end else if (a < emb_pkg::OFF_CHAN) begin
				next_st.mon_base[a[4:2]] = pwdata[31:5];
				next_st.mon_en[a[4:2]]   = pwdata[0];
			end else if (a < emb_pkg::OFF_CHEND) begin
				if (a[3:2] == 2'h0) begin
					next_st.ch_addr[a[5:4]] = pwdata;
				end else if (a[3:2] == 2'h1) begin
					next_st.ch_data[a[5:4]] = pwdata;
				end else if (a[3:2] == 2'h2) begin
					next_st.ch_cfg[a[5:4]] = pwdata;
				end
			end
		end

		// changing what is watched while running costs a short program pause
		if (next_st.mon_pause != 4'h0) begin
			next_st.mon_pause = st.mon_pause - 4'h1;
		end
		if (mon_cfg_wr && st.ctrl[emb_pkg::CTRL_RUN]) begin
			next_st.rt_lost   = 1'b1;
			next_st.mon_pause = 4'(emb_pkg::MON_UPD_CYC);
		end

		// memory access engine; the pause lasts at least the reference time
		if ((st.acc != emb_pkg::ACC_IDLE) && (st.acc_tmr != 32'h0000_0000)) begin
			next_st.acc_tmr = st.acc_tmr - 32'h0000_0001;
		end
		case (st.acc)
			emb_pkg::ACC_IDLE: begin
				if (go_cmd) begin
					if (cpu_sleep) begin
						next_st.acc_err = 1'b1;
					end else begin
						next_st.acc    = emb_pkg::ACC_HOLD;
						next_st.acc_wr = pwdata[emb_pkg::CMD_WR];
						next_st.acc_sb = pwdata[emb_pkg::CMD_SB];
						next_st.acc_tmr = pwdata[emb_pkg::CMD_SB] ? 32'(SB_CYC - 1)
							: 32'(emb_pkg::PAR_CYC - 1);
					end
				end
			end
			emb_pkg::ACC_HOLD: begin
				if (hold_ack) begin
					next_st.acc     = emb_pkg::ACC_XFER;
					next_st.mem_req = 1'b1;
				end
			end
			emb_pkg::ACC_XFER: begin
				if (mem_ack) begin
					next_st.mem_req  = 1'b0;
					next_st.acc      = emb_pkg::ACC_WAIT;
					next_st.acc_data = st.acc_wr ? st.acc_data : mem_rdata;
				end
			end
			default: begin
				if (st.acc_tmr == 32'h0000_0000) begin
					next_st.acc = emb_pkg::ACC_IDLE;
				end
			end
		endcase
		next_st.hold_req = (next_st.acc != emb_pkg::ACC_IDLE) || (next_st.mon_pause != 4'h0);

		// monitor snoops the target bus into its own copy; it never drives the bus
		for (int k = 0; k < emb_pkg::MON_CH; k++) begin
			if (tb_valid && st.mon_en[k] && (tb_addr[31:5] == st.mon_base[k])) begin
				idx = {3'(k), tb_addr[4:2]};
				old = st.mon_mem[idx];
				sh  = {tb_addr[1:0], 3'h0};
				if (tb_size == emb_pkg::SZ_LONG) begin
					next_st.mon_mem[idx] = tb_data;
				end else if (tb_size == emb_pkg::SZ_WORD) begin
					next_st.mon_mem[idx] = tb_addr[1] ? {tb_data[15:0], old[15:0]}
						: {old[31:16], tb_data[15:0]};
				end else begin
					next_st.mon_mem[idx] = (old & ~(32'h0000_00FF << sh))
						| ({24'h0, tb_data[7:0]} << sh);
				end
			end
		end

		// break sequencing: a sequential chain overrides the range break
		if (st.ctrl[emb_pkg::CTRL_SEQ]) begin
			if (st.ctrl[emb_pkg::CTRL_RSTPT] && h[2]) begin
				next_st.seq = 2'h0;
			end else if ((st.seq == 2'h0) && h[0]) begin
				next_st.seq = 2'h1;
			end else if ((st.seq == 2'h1) && h[1]) begin
				next_st.seq = 2'h2;
			end else if ((st.seq == 2'h2) && h[3]) begin
				next_st.seq = 2'h0;
				fire = 1'b1;
			end
		end else begin
			next_st.seq = 2'h0;
			if (st.ctrl[emb_pkg::CTRL_RANGE]) begin
				fire = h[2] | h[3] | (tb_valid && st.ch_cfg[0][emb_pkg::CFG_EN]
					&& (tb_addr >= st.ch_addr[0]) && (tb_addr <= st.ch_addr[1]));
			end else begin
				fire = |h;
			end
		end
		// step mode keeps trigger pulses but drops the break itself
		next_st.trig_out = fire;
		if (fire && !st.ctrl[emb_pkg::CTRL_STEP]) begin
			next_st.brk_req  = 1'b1;
			next_st.brk_seen = 1'b1;
		end

		// software breakpoint: substitute the opcode only while the program runs
		next_st.sw_act = st.ctrl[emb_pkg::CTRL_RUN] & st.sw_en & sw_ok;
		if (sw_hit) begin
			if (tb_slot) begin
				next_st.slot_illegal = 1'b1;
			end else if (!st.ctrl[emb_pkg::CTRL_STEP]) begin
				next_st.brk_req  = 1'b1;
				next_st.brk_seen = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st      <= '0;
			st.ctrl <= emb_pkg::CTRL_RST;
			st.acc  <= emb_pkg::ACC_IDLE;
		end else begin
			st <= next_st;
		end
	end

	assign prdata       = st.prdata;
	assign pready       = st.pready;
	assign pslverr      = st.pslverr;
	assign hold_req     = st.hold_req;
	assign mem_req      = st.mem_req;
	assign mem_we       = st.acc_wr;
	assign mem_addr     = st.acc_addr;
	assign mem_wdata    = st.acc_data;
	assign subst_en     = st.sw_act;
	assign subst_addr   = st.sw_addr;
	assign subst_op     = BRK_OPCODE;
	assign brk_req      = st.brk_req;
	assign trig_out     = st.trig_out;
	assign slot_illegal = st.slot_illegal;

	AST_SLEEP_REFUSE: assert property (@(posedge clk) disable iff (!arst_n)
		(go_cmd && cpu_sleep && st.acc == emb_pkg::ACC_IDLE)
			|=> (st.acc == emb_pkg::ACC_IDLE) && st.acc_err && !st.hold_req)
		else $error("access started during sleep");
	AST_PAR_PAUSE: assert property (@(posedge clk) disable iff (!arst_n)
		(st.acc == emb_pkg::ACC_HOLD && $past(st.acc) == emb_pkg::ACC_IDLE && !st.acc_sb)
			|-> st.hold_req [*6])
		else $error("parallel pause shorter than reference");
	AST_STEP_NO_BRK: assert property (@(posedge clk) disable iff (!arst_n)
		st.ctrl[emb_pkg::CTRL_STEP] |=> !st.brk_req)
		else $error("break raised in step mode");
	AST_STEP_TRIG: assert property (@(posedge clk) disable iff (!arst_n)
		(!st.ctrl[emb_pkg::CTRL_SEQ] && !st.ctrl[emb_pkg::CTRL_RANGE] && h != 4'h0)
			|=> st.trig_out)
		else $error("trigger pulse missing");
	AST_RANGE_OFF: assert property (@(posedge clk) disable iff (!arst_n)
		(st.ctrl[emb_pkg::CTRL_SEQ] && !(st.seq == 2'h2 && h[3])) |=> !st.trig_out)
		else $error("break outside the sequential chain");
	AST_RST_POINT: assert property (@(posedge clk) disable iff (!arst_n)
		(st.ctrl[emb_pkg::CTRL_SEQ] && st.ctrl[emb_pkg::CTRL_RSTPT] && h[2])
			|=> st.seq == 2'h0)
		else $error("reset point did not restart the sequence");
	AST_SLOT_NO_BRK: assert property (@(posedge clk) disable iff (!arst_n)
		(sw_hit && tb_slot && !st.ctrl[emb_pkg::CTRL_SEQ] && !st.ctrl[emb_pkg::CTRL_RANGE]
			&& h == 4'h0) |=> st.slot_illegal && !st.brk_req)
		else $error("delay slot breakpoint handled wrongly");
	AST_SW_LEGAL: assert property (@(posedge clk) disable iff (!arst_n)
		st.sw_act |-> $past(sw_ok) && $past(st.ctrl[emb_pkg::CTRL_RUN]))
		else $error("software breakpoint armed illegally");
	AST_RT_LOST: assert property (@(posedge clk) disable iff (!arst_n)
		(mon_cfg_wr && st.ctrl[emb_pkg::CTRL_RUN]) |=> st.rt_lost && st.hold_req)
		else $error("monitor change did not pause program");
	AST_MEM_ONLY_ACC: assert property (@(posedge clk) disable iff (!arst_n)
		st.mem_req |-> st.acc == emb_pkg::ACC_XFER && st.hold_req)
		else $error("memory request outside a paused access");
endmodule : emb_top

// ---- inc/emb_pkg.sv ----
package emb_pkg;
	// clock and reference pause figures
	localparam int CLK_NS          = 40;
	localparam int PAR_NS          = 220;
	localparam int PAR_CYC         = (PAR_NS + CLK_NS - 1) / CLK_NS;
	localparam int SB_LONG_NS      = 1800000;
	localparam int SB_LONG_CYC     = (SB_LONG_NS + CLK_NS - 1) / CLK_NS;
	localparam int MON_UPD_CYC     = 4;

	// monitor geometry: eight windows of 32 bytes, 256 bytes in all
	localparam int MON_CH          = 8;
	localparam int MON_WORDS       = 64;
	localparam int BRK_CH          = 4;
	localparam int BRK_CNT_IDX     = 3;

	// register byte offsets
	localparam logic [11:0] OFF_CTRL   = 12'h000;
	localparam logic [11:0] OFF_STAT   = 12'h004;
	localparam logic [11:0] OFF_SWBP   = 12'h008;
	localparam logic [11:0] OFF_SWORIG = 12'h00C;
	localparam logic [11:0] OFF_ACCA   = 12'h010;
	localparam logic [11:0] OFF_ACCD   = 12'h014;
	localparam logic [11:0] OFF_ACCC   = 12'h018;
	localparam logic [11:0] OFF_MONFMT = 12'h01C;
	localparam logic [11:0] OFF_MONW   = 12'h020;
	localparam logic [11:0] OFF_CHAN   = 12'h040;
	localparam logic [11:0] OFF_CHEND  = 12'h080;
	localparam logic [11:0] OFF_MONMEM = 12'h100;
	localparam logic [11:0] OFF_MEMEND = 12'h200;

	// control bits
	localparam int CTRL_RUN   = 0;
	localparam int CTRL_STEP  = 1;
	localparam int CTRL_SEQ   = 2;
	localparam int CTRL_RANGE = 3;
	localparam int CTRL_RSTPT = 4;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;

	// status bits
	localparam int ST_RTLOST  = 0;
	localparam int ST_BUSY    = 1;
	localparam int ST_ACCERR  = 2;
	localparam int ST_BRK     = 3;
	localparam int ST_SWACT   = 4;
	localparam int ST_SEQ     = 5;

	// access command bits
	localparam int CMD_GO = 0;
	localparam int CMD_WR = 1;
	localparam int CMD_SB = 2;

	// break channel config fields
	localparam int CFG_EN  = 0;
	localparam int CFG_AEN = 1;
	localparam int CFG_DEN = 2;
	localparam int CFG_SZ  = 4;
	localparam int CFG_CNT = 8;

	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_WORD = 2'h1;
	localparam logic [1:0] SZ_LONG = 2'h2;

	typedef enum logic [1:0] {
		ACC_IDLE = 2'h0,
		ACC_HOLD = 2'h1,
		ACC_XFER = 2'h3,
		ACC_WAIT = 2'h2
	} emb_acc_t;

	// condition address is usable only when aligned to its size
	function automatic logic emb_addr_ok(input logic [1:0] sz, input logic [31:0] a);
		emb_addr_ok = (sz == SZ_LONG) ? (a[1:0] == 2'h0) :
			(sz == SZ_WORD) ? (a[0] == 1'b0) : 1'b1;
	endfunction : emb_addr_ok

	// compare only the lanes the size covers
	function automatic logic emb_data_eq(input logic [1:0] sz, input logic [31:0] a,
			input logic [31:0] b);
		emb_data_eq = (sz == SZ_LONG) ? (a == b) :
			(sz == SZ_WORD) ? (a[15:0] == b[15:0]) : (a[7:0] == b[7:0]);
	endfunction : emb_data_eq
endpackage : emb_pkg

// ---- inc/emb_chan_if.sv ----
`timescale 1ns/1ps
interface emb_chan_if;
	logic        en;
	logic        aen;
	logic        den;
	logic [1:0]  size;
	logic [31:0] addr;
	logic [31:0] data;
	logic [15:0] count;
	logic        bvalid;
	logic [31:0] baddr;
	logic [31:0] bdata;
	logic [1:0]  bsize;
	logic        hit;
	modport top  (output en, aen, den, size, addr, data, count, bvalid, baddr, bdata, bsize,
		input hit);
	modport chan (input en, aen, den, size, addr, data, count, bvalid, baddr, bdata, bsize,
		output hit);
endinterface : emb_chan_if

// ---- verilog/emb_chan.sv ----
`timescale 1ns/1ps
module emb_chan #(
	parameter bit HAS_COUNT = 1'b0
) (
	input wire logic clk,
	input wire logic arst_n,
	emb_chan_if.chan cif
);
	typedef struct packed {
		logic [15:0] cnt;
		logic        hit;
	} emb_chan_st_t;

	emb_chan_st_t st;
	emb_chan_st_t next_st;
	logic         match;

	// a condition is met only on the bus cycle whose values equal it
	assign match = cif.en & cif.bvalid & (cif.aen | cif.den)
		& (~cif.aen | (emb_pkg::emb_addr_ok(cif.size, cif.addr) & (cif.addr == cif.baddr)))
		& (~cif.den | ((cif.size == cif.bsize)
			& emb_pkg::emb_data_eq(cif.size, cif.data, cif.bdata)));

	// the satisfaction count exists only on the counting channel
	always_comb begin
		next_st = st;
		next_st.hit = 1'b0;
		if (match) begin
			if (HAS_COUNT) begin
				next_st.cnt = st.cnt + 16'h0001;
				if (next_st.cnt >= cif.count) begin
					next_st.hit = 1'b1;
					next_st.cnt = 16'h0000;
				end
			end else begin
				next_st.hit = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign cif.hit = st.hit;

	AST_CH_SIZE: assert property (@(posedge clk) disable iff (!arst_n)
		(st.hit && !HAS_COUNT) |-> $past(cif.bvalid)
			&& (!$past(cif.den) || ($past(cif.bsize) == $past(cif.size))))
		else $error("channel hit without a matching bus cycle");
endmodule : emb_chan

// ---- verification/emb_cpu_model.sv ----
`timescale 1ns/1ps
module emb_cpu_model #(
	parameter int DLY = 2
) (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        hold_req,
	input  wire logic        mem_req,
	input  wire logic [31:0] mem_addr,
	output logic             hold_ack,
	output logic             mem_ack,
	output logic      [31:0] mem_rdata
);
	int wait_cnt;

	// pause granted only after the current cycle finishes, one ack per request
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wait_cnt  <= 0;
			hold_ack  <= 1'h0;
			mem_ack   <= 1'h0;
			mem_rdata <= 32'h0;
		end else begin
			wait_cnt <= hold_req ? wait_cnt + 1 : 0;
			hold_ack <= hold_req && (wait_cnt >= DLY);
			mem_ack  <= mem_req && !mem_ack;
			// released data lines move every cycle so stale data never matches
			if (mem_req && !mem_ack)
				mem_rdata <= ~mem_addr;
			else
				mem_rdata <= {mem_rdata[30:0], ~mem_rdata[31]};
		end
	end
endmodule : emb_cpu_model

// ---- verification/emb_top_tb_top.sv ----
`timescale 1ns/1ps
module emb_top_tb_top;
	localparam logic [31:0] EMU = 32'h0040_0000;
	localparam logic [15:0] OPC = 16'h1F3C; // arbitrary break opcode
	logic        clk = 0;
	logic        arst_n = 0;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [31:0] paddr = 0;
	logic [31:0] pwdata = 0;
	logic        tb_valid = 0, tb_write = 0, tb_fetch = 0, tb_slot = 0, cpu_sleep = 0;
	logic [1:0]  tb_size = 0;
	logic [31:0] tb_addr = 0, tb_data = 0;
	logic        pready, pslverr, hold_ack, hold_req, mem_req, mem_we, mem_ack;
	logic        subst_en, brk_req, trig_out, slot_illegal, e;
	logic [31:0] prdata, mem_addr, mem_wdata, mem_rdata, subst_addr, q;
	logic [15:0] subst_op;
	int          err_count = 0, checked = 0, n_hold = 0, n_brk = 0, n_trig = 0, n_slot = 0;
	int          h, b, t;
	logic [31:0] w_seen = 0;

	always #20 clk = ~clk;

	emb_top #(.SB_CYC(20), .EMU_BASE(EMU), .BRK_OPCODE(OPC)) dut (.clk, .arst_n, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .tb_valid,
		.tb_write, .tb_fetch, .tb_slot, .tb_size, .tb_addr, .tb_data, .cpu_sleep,
		.hold_ack, .hold_req, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
		.mem_rdata, .subst_en, .subst_addr, .subst_op, .brk_req, .trig_out, .slot_illegal);
	emb_cpu_model #(.DLY(2)) cpu (.clk, .arst_n, .hold_req, .mem_req, .mem_addr,
		.hold_ack, .mem_ack, .mem_rdata);

	// counts move by nba so a test reading them at an edge sees settled values
	always @(posedge clk) begin
		n_hold <= n_hold + hold_req;
		n_brk  <= n_brk + brk_req;
		n_trig <= n_trig + trig_out;
		n_slot <= n_slot + slot_illegal;
		// last word offered on a write access, taken while the request stands
		if (mem_req && mem_we)
			w_seen <= mem_wdata;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// request held until pready is seen high at an edge, then released
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel   <= 1'h1;
		pwrite <= wr;
		paddr  <= {20'h0, a};
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		q = prdata;
		e = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask : xfer

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'h1, a, d);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		xfer(1'h0, a, 32'h0);
		chk(q, exp);
	endtask : rd

	// start a memory access and poll busy; h returns the paused cycles
	task automatic acc(input logic [31:0] cmd);
		h = n_hold;
		wr(emb_pkg::OFF_ACCC, cmd);
		for (int i = 0; i < 100; i++) begin
			xfer(1'h0, emb_pkg::OFF_STAT, 32'h0);
			if (q[emb_pkg::ST_BUSY] !== 1'h1)
				break;
		end
		chk(q[emb_pkg::ST_BUSY], 0);
		h = n_hold - h;
	endtask : acc

	// one target bus cycle, idle after it so the break pipeline drains
	task automatic ev(input logic [2:0] k, input logic [1:0] sz, input logic [31:0] a,
			input logic [31:0] d, input int nb);
		b = n_brk;
		{tb_write, tb_fetch, tb_slot} <= k;
		tb_valid <= 1'h1;
		tb_size  <= sz;
		tb_addr  <= a;
		tb_data  <= d;
		@(posedge clk);
		tb_valid <= 1'h0;
		repeat (4) @(posedge clk);
		chk(n_brk - b, nb);
	endtask : ev

	task automatic close_out;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out

	initial begin
		repeat (3) @(posedge clk);
		arst_n <= 1'h1;
		@(posedge clk);
		rd(emb_pkg::OFF_CTRL, emb_pkg::CTRL_RST);
		xfer(1'h0, 12'h080, 32'h0);
		chk(e, 1);
		$display("test regs done");
		wr(emb_pkg::OFF_ACCA, EMU + 32'h10);
		acc(32'h1);
		chk(h >= emb_pkg::PAR_CYC, 1);
		rd(emb_pkg::OFF_ACCD, ~(EMU + 32'h10));
		wr(emb_pkg::OFF_ACCD, 32'h5A5A_1234);
		acc(32'h3);
		chk(w_seen, 32'h5A5A_1234);
		rd(emb_pkg::OFF_ACCD, 32'h5A5A_1234);
		acc(32'h5);
		chk(h >= 20, 1);
		cpu_sleep <= 1'h1;
		acc(32'h1);
		chk(h, 0);
		chk(q[emb_pkg::ST_ACCERR], 1);
		wr(emb_pkg::OFF_STAT, 32'h4);
		xfer(1'h0, emb_pkg::OFF_STAT, 32'h0);
		chk(q[emb_pkg::ST_ACCERR], 0);
		cpu_sleep <= 1'h0;
		$display("test access done");
		wr(emb_pkg::OFF_CTRL, 32'h1);
		h = n_hold;
		wr(emb_pkg::OFF_MONW, 32'h0000_1001);
		repeat (6) @(posedge clk);
		chk(n_hold - h >= emb_pkg::MON_UPD_CYC, 1);
		xfer(1'h0, emb_pkg::OFF_STAT, 32'h0);
		chk(q[emb_pkg::ST_RTLOST], 1);
		ev(3'h4, emb_pkg::SZ_LONG, 32'h1008, 32'hCAFE_0123, 0);
		// a range running past 0x101F takes a second window
		wr(emb_pkg::OFF_MONW + 12'h4, 32'h0000_1021);
		ev(3'h4, emb_pkg::SZ_LONG, 32'h1028, 32'h0BAD_0BAD, 0);
		rd(emb_pkg::OFF_MONMEM + 12'h008, 32'hCAFE_0123);
		rd(emb_pkg::OFF_MONMEM + 12'h028, 32'h0BAD_0BAD);
		$display("test monitor done");
		wr(emb_pkg::OFF_CHAN, 32'h2000);
		wr(emb_pkg::OFF_CHAN + 12'h8, 32'h23);
		ev(3'h0, emb_pkg::SZ_LONG, 32'h2000, 32'h0, 1);
		ev(3'h0, emb_pkg::SZ_LONG, 32'h2004, 32'h0, 0);
		wr(emb_pkg::OFF_CTRL, 32'h3);
		t = n_trig;
		ev(3'h0, emb_pkg::SZ_LONG, 32'h2000, 32'h0, 0);
		chk(n_trig - t, 1);
		wr(emb_pkg::OFF_CTRL, 32'h1);
		wr(emb_pkg::OFF_CHAN, 32'h2002);
		ev(3'h0, emb_pkg::SZ_LONG, 32'h2002, 32'h0, 0);
		wr(emb_pkg::OFF_CHAN + 12'h8, 32'h13);
		ev(3'h0, emb_pkg::SZ_WORD, 32'h2002, 32'h0, 1);
		wr(emb_pkg::OFF_CHAN, 32'h2001);
		ev(3'h0, emb_pkg::SZ_WORD, 32'h2001, 32'h0, 0);
		wr(emb_pkg::OFF_CHAN + 12'h4, 32'h55);
		wr(emb_pkg::OFF_CHAN + 12'h8, 32'h07);
		ev(3'h4, emb_pkg::SZ_BYTE, 32'h2001, 32'h55, 1);
		ev(3'h4, emb_pkg::SZ_BYTE, 32'h2001, 32'h56, 0);
		// only the fourth channel may hold back its break until the count
		for (int n = 2; n < 4; n++) begin
			wr(emb_pkg::OFF_CHAN + 12'(16 * n), 32'h3000);
			wr(emb_pkg::OFF_CHAN + 12'(16 * n + 8), 32'h323);
			t = n_brk;
			for (int j = 0; j < 3; j++)
				ev(3'h0, emb_pkg::SZ_LONG, 32'h3000, 32'h0, (n == 3) ? int'(j == 2) : 1);
			chk(n_brk - t, (n == 3) ? 1 : 3);
			wr(emb_pkg::OFF_CHAN + 12'(16 * n + 8), 32'h0);
		end
		$display("test break done");
		wr(emb_pkg::OFF_CHAN, 32'h100);
		wr(emb_pkg::OFF_CHAN + 12'h8, 32'h23);
		wr(emb_pkg::OFF_CHAN + 12'h10, 32'h200);
		wr(emb_pkg::OFF_CHAN + 12'h18, 32'h23);
		wr(emb_pkg::OFF_CTRL, 32'h9);
		ev(3'h0, emb_pkg::SZ_LONG, 32'h180, 32'h0, 1);
		wr(emb_pkg::OFF_CTRL, 32'hD);
		ev(3'h0, emb_pkg::SZ_LONG, 32'h180, 32'h0, 0);
		// chain ch0 then ch1 then ch3; ch2 restarts it only while chaining
		wr(emb_pkg::OFF_CHAN + 12'h20, 32'h400);
		wr(emb_pkg::OFF_CHAN + 12'h28, 32'h23);
		wr(emb_pkg::OFF_CHAN + 12'h30, 32'h300);
		wr(emb_pkg::OFF_CHAN + 12'h38, 32'h23);
		wr(emb_pkg::OFF_CTRL, 32'h5);
		ev(3'h0, emb_pkg::SZ_LONG, 32'h100, 32'h0, 0);
		ev(3'h0, emb_pkg::SZ_LONG, 32'h200, 32'h0, 0);
		ev(3'h0, emb_pkg::SZ_LONG, 32'h300, 32'h0, 1);
		wr(emb_pkg::OFF_CTRL, 32'h15);
		ev(3'h0, emb_pkg::SZ_LONG, 32'h100, 32'h0, 0);
		ev(3'h0, emb_pkg::SZ_LONG, 32'h400, 32'h0, 0);
		ev(3'h0, emb_pkg::SZ_LONG, 32'h200, 32'h0, 0);
		ev(3'h0, emb_pkg::SZ_LONG, 32'h300, 32'h0, 0);
		wr(emb_pkg::OFF_CTRL, 32'h11);
		ev(3'h0, emb_pkg::SZ_LONG, 32'h400, 32'h0, 1);
		wr(emb_pkg::OFF_CTRL, 32'h1);
		wr(emb_pkg::OFF_CHAN + 12'h8, 32'h0);
		wr(emb_pkg::OFF_CHAN + 12'h18, 32'h0);
		$display("test range done");
		wr(emb_pkg::OFF_SWORIG, 32'h1234);
		wr(emb_pkg::OFF_SWBP, EMU + 32'h21);
		repeat (2) @(posedge clk);
		chk({subst_en, subst_op}, {1'h1, OPC});
		chk(subst_addr, EMU + 32'h20);
		t = n_slot;
		ev(3'h3, emb_pkg::SZ_WORD, EMU + 32'h20, 32'h0, 0);
		chk(n_slot - t, 1);
		ev(3'h2, emb_pkg::SZ_WORD, EMU + 32'h20, 32'h0, 1);
		wr(emb_pkg::OFF_SWORIG, 32'h0);
		repeat (2) @(posedge clk);
		chk(subst_en, 0);
		wr(emb_pkg::OFF_SWORIG, 32'h1234);
		wr(emb_pkg::OFF_SWBP, 32'h21);
		repeat (2) @(posedge clk);
		chk(subst_en, 0);
		$display("test soft break done");
		close_out();
	end

	// the sequence needs a few hundred cycles; this span is far beyond it
	initial begin
		#2_000_000;
		err_count++;
		close_out();
	end
endmodule : emb_top_tb_top
